// ### design/acs_sequencer.sv
// Conversion sequencer of a successive-approximation converter
// Function
// - 10-bit takes 11, 12-bit 13 periods
// - Clock select field sets bit period
// - Analog pins read zero on port
// - Sequence ignores channel and direction bits
// - No acquisition: start after one instruction
// - Acquisition code 010 samples four periods
// - Clearing go aborts, result untouched
// - Result keeps last conversion or write
// - Two period wait then sampling resumes
// - Enabled trigger sets go like software
// - Disabled converter ignores triggers
// - Trigger source field selects origin
// - Compare trigger clears timer always
// - Calibration request stores offset, compensates later
// - Completion loads result (offset on a calibration run), clears go, flags
// - Acquisition field resets to none
`timescale 1ns/1ns
module acs_sequencer (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic rc_clk_i,
    input wire logic cmp_i,
    input wire logic [7:0] port_pins_i,
    input wire logic trig_compare_i,
    input wire logic trig_charge_i,
    input wire logic trig_timer_i,
    input wire logic trig_calendar_i,
    output logic timer_clear_o,
    output logic sample_o,
    output logic [3:0] channel_select_o,
    output logic [11:0] dac_code_o
);
    // ==========================================
    // Synchronisers for pin inputs
    logic [2:0] rc_sync_ff;
    logic [1:0] cmp_sync_ff;
    logic [7:0] pin_s1_ff;
    logic [7:0] pin_s2_ff;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rc_sync_ff <= 3'h0;
            cmp_sync_ff <= 2'h0;
            pin_s1_ff <= 8'h00;
            pin_s2_ff <= 8'h00;
        end else begin
            rc_sync_ff <= {rc_sync_ff[1:0], rc_clk_i};
            cmp_sync_ff <= {cmp_sync_ff[0], cmp_i};
            pin_s1_ff <= port_pins_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // ==========================================
    // Registers and state
    logic [7:0] ctrl0_ff, nxt_ctrl0;
    logic [7:0] ctrl1_ff, nxt_ctrl1;
    logic [7:0] ana_cfg_ff, nxt_ana_cfg;
    logic [1:0] trig_sel_ff, nxt_trig_sel;
    logic [11:0] result_ff, nxt_result;
    logic [11:0] offset_ff, nxt_offset;
    logic done_ff, nxt_done;
    logic [7:0] rdata_ff, nxt_rdata;
    logic timer_clr_ff, nxt_timer_clr;
    acs_pkg::acs_state_t state_ff, nxt_state;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [5:0] div_ff, nxt_div;
    logic [11:0] sar_ff, nxt_sar;
    logic [11:0] trial_ff, nxt_trial;
    logic cal_run_ff, nxt_cal_run;

    logic conv_on;
    logic go;
    logic [2:0] clk_sel;
    logic [2:0] acq_sel;
    logic mode12;
    logic [5:0] div_last;
    logic tick;
    logic trig_pick;
    logic wr_ctrl0;
    logic [4:0] conv_len;
    logic [4:0] acq_len;

    assign conv_on = ctrl0_ff[acs_pkg::C0_ON];
    assign go = ctrl0_ff[acs_pkg::C0_GO];
    assign clk_sel = ctrl1_ff[acs_pkg::C1_CS +: 3];
    assign acq_sel = ctrl1_ff[acs_pkg::C1_ACQ +: 3];
    assign mode12 = ctrl1_ff[acs_pkg::C1_MODE12];
    assign wr_ctrl0 = wr_i && (addr_i == acs_pkg::OFS_CTRL0);
    assign conv_len = mode12 ? acs_pkg::CONV_TAD_12 : acs_pkg::CONV_TAD_10;
    assign acq_len = {1'b0, acq_sel, 1'b0};

    // ==========================================
    // Bit period divider
    // Divide ratio is 2 shifted by twice the low pair plus the top bit
    always_comb begin
        div_last = 6'((7'h02 << {clk_sel[1:0], 1'b0} + {2'h0, clk_sel[2]}) - 7'h01);
        if (clk_sel[1:0] == acs_pkg::CS_RC) begin
            tick = rc_sync_ff[1] && !rc_sync_ff[2];
            nxt_div = 6'h00;
        end else begin
            tick = (div_ff == div_last);
            nxt_div = tick ? 6'h00 : div_ff + 6'h01;
        end
    end

    // ==========================================
    // Trigger selection
    always_comb begin
        unique case (trig_sel_ff)
            acs_pkg::TRG_COMPARE: trig_pick = trig_compare_i;
            acs_pkg::TRG_CHARGE: trig_pick = trig_charge_i;
            acs_pkg::TRG_TIMER: trig_pick = trig_timer_i;
            acs_pkg::TRG_CALENDAR: trig_pick = trig_calendar_i;
        endcase
        nxt_timer_clr = trig_compare_i;
    end

    // ==========================================
    // Register writes and sequencer
    always_comb begin
        nxt_ctrl0 = ctrl0_ff;
        nxt_ctrl1 = ctrl1_ff;
        nxt_ana_cfg = ana_cfg_ff;
        nxt_trig_sel = trig_sel_ff;
        nxt_result = result_ff;
        nxt_offset = offset_ff;
        nxt_done = done_ff;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sar = sar_ff;
        nxt_trial = trial_ff;
        nxt_cal_run = cal_run_ff;
        if (wr_i) begin
            unique case (addr_i)
                acs_pkg::OFS_CTRL0: begin
                    nxt_ctrl0 = wdata_i;
                    // Go only counts once the converter was already on
                    nxt_ctrl0[acs_pkg::C0_GO] = wdata_i[acs_pkg::C0_GO] && conv_on;
                end
                acs_pkg::OFS_CTRL1: nxt_ctrl1 = wdata_i;
                acs_pkg::OFS_RES_HI: nxt_result[11:8] = wdata_i[3:0];
                acs_pkg::OFS_RES_LO: nxt_result[7:0] = wdata_i;
                acs_pkg::OFS_ANA_CFG: nxt_ana_cfg = wdata_i;
                acs_pkg::OFS_STATUS: begin
                    if (!wdata_i[acs_pkg::ST_DONE]) begin
                        nxt_done = 1'b0;
                    end
                end
                acs_pkg::OFS_TRIG_SEL: nxt_trig_sel = wdata_i[1:0];
                default: begin
                end
            endcase
        end
        unique case (state_ff)
            acs_pkg::ST_IDLE: begin
                if (go) begin
                    nxt_cnt = 5'h00;
                    if (acq_sel == acs_pkg::ACQ_NONE) begin
                        nxt_state = acs_pkg::ST_WAIT;
                    end else begin
                        nxt_state = acs_pkg::ST_ACQ;
                    end
                end
            end
            acs_pkg::ST_WAIT: begin
                nxt_cnt = cnt_ff + 5'h01;
                if (cnt_ff == acs_pkg::INSTR_CLKS - 5'h01) begin
                    nxt_state = acs_pkg::ST_CONV;
                    nxt_cnt = 5'h00;
                end
            end
            acs_pkg::ST_ACQ: begin
                if (tick) begin
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == acq_len - 5'h01) begin
                        nxt_state = acs_pkg::ST_CONV;
                        nxt_cnt = 5'h00;
                    end
                end
            end
            acs_pkg::ST_CONV: begin
                if (tick) begin
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == 5'h00) begin
                        // First period holds the sample and loads the top trial
                        nxt_cal_run = ctrl1_ff[acs_pkg::C1_CAL];
                        nxt_trial = mode12 ? 12'h800 : 12'h200;
                        nxt_sar = nxt_trial;
                    end else begin
                        nxt_sar = cmp_sync_ff[1] ? sar_ff : sar_ff & ~trial_ff;
                        nxt_trial = trial_ff >> 1;
                        nxt_sar = nxt_sar | nxt_trial;
                    end
                    if (cnt_ff == conv_len - 5'h01) begin
                        if (cal_run_ff) begin
                            nxt_offset = nxt_sar;
                        end else begin
                            nxt_result = (nxt_sar > offset_ff) ?
                                nxt_sar - offset_ff : 12'h000;
                        end
                        nxt_done = 1'b1;
                        nxt_ctrl0[acs_pkg::C0_GO] = 1'b0;
                        nxt_state = acs_pkg::ST_POST;
                        nxt_cnt = 5'h00;
                    end
                end
            end
            acs_pkg::ST_POST: begin
                if (tick) begin
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == acs_pkg::POST_TAD - 5'h01) begin
                        nxt_state = acs_pkg::ST_IDLE;
                    end
                end
            end
            default: nxt_state = acs_pkg::ST_IDLE;
        endcase
        // Abort leaves the result pair alone
        if (!go && (state_ff == acs_pkg::ST_WAIT || state_ff == acs_pkg::ST_ACQ ||
                state_ff == acs_pkg::ST_CONV)) begin
            nxt_state = acs_pkg::ST_POST;
            nxt_result = result_ff;
            nxt_cnt = 5'h00;
        end
        // Trigger acts like a software start, set beats a hardware clear
        if (trig_pick && conv_on) begin
            nxt_ctrl0[acs_pkg::C0_GO] = 1'b1;
        end
        if (wr_ctrl0 && wdata_i[acs_pkg::C0_GO] && conv_on) begin
            nxt_ctrl0[acs_pkg::C0_GO] = 1'b1;
        end
        if (!nxt_ctrl0[acs_pkg::C0_ON]) begin
            nxt_ctrl0[acs_pkg::C0_GO] = 1'b0;
            nxt_state = acs_pkg::ST_IDLE;
        end
    end

    // ==========================================
    // Read data, one cycle after the strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                acs_pkg::OFS_CTRL0: nxt_rdata = ctrl0_ff;
                acs_pkg::OFS_CTRL1: nxt_rdata = ctrl1_ff;
                acs_pkg::OFS_RES_HI: nxt_rdata = {4'h0, result_ff[11:8]};
                acs_pkg::OFS_RES_LO: nxt_rdata = result_ff[7:0];
                acs_pkg::OFS_ANA_CFG: nxt_rdata = ana_cfg_ff;
                acs_pkg::OFS_PORT_IN: nxt_rdata = pin_s2_ff & ana_cfg_ff;
                acs_pkg::OFS_STATUS: nxt_rdata = {4'h0, state_ff, done_ff};
                acs_pkg::OFS_TRIG_SEL: nxt_rdata = {6'h00, trig_sel_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // ==========================================
    // State registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl0_ff <= acs_pkg::RST_CTRL0;
            ctrl1_ff <= acs_pkg::RST_CTRL1;
            ana_cfg_ff <= acs_pkg::RST_ANA_CFG;
            trig_sel_ff <= acs_pkg::RST_TRIG_SEL;
            result_ff <= 12'h000;
            offset_ff <= 12'h000;
            done_ff <= 1'b0;
            rdata_ff <= 8'h00;
            timer_clr_ff <= 1'b0;
            state_ff <= acs_pkg::ST_IDLE;
            cnt_ff <= 5'h00;
            div_ff <= 6'h00;
            sar_ff <= 12'h000;
            trial_ff <= 12'h000;
            cal_run_ff <= 1'b0;
        end else begin
            ctrl0_ff <= nxt_ctrl0;
            ctrl1_ff <= nxt_ctrl1;
            ana_cfg_ff <= nxt_ana_cfg;
            trig_sel_ff <= nxt_trig_sel;
            result_ff <= nxt_result;
            offset_ff <= nxt_offset;
            done_ff <= nxt_done;
            rdata_ff <= nxt_rdata;
            timer_clr_ff <= nxt_timer_clr;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            div_ff <= nxt_div;
            sar_ff <= nxt_sar;
            trial_ff <= nxt_trial;
            cal_run_ff <= nxt_cal_run;
        end
    end

    // ==========================================
    // Outputs
    // Channel select only steers the front end, never the sequence
    assign channel_select_o = ctrl0_ff[acs_pkg::C0_CHS +: 4];
    assign sample_o = conv_on && (state_ff == acs_pkg::ST_IDLE ||
        state_ff == acs_pkg::ST_WAIT || state_ff == acs_pkg::ST_ACQ);
    assign dac_code_o = sar_ff;
    assign rdata_o = rdata_ff;
    assign timer_clear_o = timer_clr_ff;
endmodule

// ### include/acs_pkg.sv
// Package of constants for the converter sequencing block
package acs_pkg;
    // ==========================================
    // Register offsets
    localparam logic [11:0] OFS_CTRL0 = 12'heb0;
    localparam logic [11:0] OFS_CTRL1 = 12'heb1;
    localparam logic [11:0] OFS_RES_HI = 12'heb2;
    localparam logic [11:0] OFS_RES_LO = 12'heb3;
    localparam logic [11:0] OFS_ANA_CFG = 12'heb4;
    localparam logic [11:0] OFS_PORT_IN = 12'heb5;
    localparam logic [11:0] OFS_STATUS = 12'heb6;
    localparam logic [11:0] OFS_TRIG_SEL = 12'heb8;
    // ==========================================
    // Field positions
    localparam int C0_ON = 0;
    localparam int C0_GO = 1;
    localparam int C0_CHS = 2;
    localparam int C1_CS = 0;
    localparam int C1_ACQ = 3;
    localparam int C1_CAL = 6;
    localparam int C1_MODE12 = 7;
    localparam int ST_DONE = 0;
    localparam int ST_STATE = 1;
    // ==========================================
    // Reset values
    localparam logic [7:0] RST_CTRL0 = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_ANA_CFG = 8'hff;
    localparam logic [1:0] RST_TRIG_SEL = 2'h0;
    // ==========================================
    // Timing counts in conversion bit periods or clocks
    localparam logic [4:0] CONV_TAD_10 = 5'h0b;
    localparam logic [4:0] CONV_TAD_12 = 5'h0d;
    localparam logic [4:0] POST_TAD = 5'h02;
    localparam logic [4:0] INSTR_CLKS = 5'h04;
    localparam logic [2:0] ACQ_NONE = 3'h0;
    // ==========================================
    // Selections
    localparam logic [1:0] TRG_COMPARE = 2'h0;
    localparam logic [1:0] TRG_CHARGE = 2'h1;
    localparam logic [1:0] TRG_TIMER = 2'h2;
    localparam logic [1:0] TRG_CALENDAR = 2'h3;
    localparam logic [1:0] CS_RC = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_ACQ = 3'b010,
        ST_CONV = 3'b011,
        ST_POST = 3'b100
    } acs_state_t;
endpackage

// ### testbench/acs_sequencer_monitor.sv
// Port checker of the conversion sequencer
`timescale 1ns/1ns
module acs_sequencer_monitor (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic trig_compare_i,
    input wire logic timer_clear_o,
    input wire logic sample_o,
    input wire logic [3:0] channel_select_o,
    input wire logic [11:0] dac_code_o
);
    // ==========================================
    // Sequences
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence ctrl_wr_s;
        wr_i && addr_i == acs_pkg::OFS_CTRL0;
    endsequence
    sequence rd_at_s(logic [11:0] a);
        rd_i && addr_i == a;
    endsequence
    property chan_p;
        ctrl_wr_s |=> channel_select_o == $past(wdata_i[5:2]);
    endproperty
    // ==========================================
    // Assertions
    idle_rdata_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    timer_clear_a: assert property (timer_clear_o == $past(trig_compare_i))
        else $error("timer clear does not follow compare trigger");
    chan_follow_a: assert property (chan_p)
        else $error("channel select not taken from control write");
    trig_upper_a: assert property (rd_at_s(acs_pkg::OFS_TRIG_SEL) |=> rdata_o[7:2] == 6'h00)
        else $error("trigger select upper bits not zero");
    res_hi_a: assert property (rd_at_s(acs_pkg::OFS_RES_HI) |=> rdata_o[7:4] == 4'h0)
        else $error("result high byte upper nibble not zero");
    status_upper_a: assert property (rd_at_s(acs_pkg::OFS_STATUS) |=> rdata_o[7:4] == 4'h0)
        else $error("status upper bits not zero");
    off_no_sample_a: assert property ((ctrl_wr_s ##0 !wdata_i[0]) |-> ##2 !sample_o [*3])
        else $error("sampling while converter off");
    reset_out_a: assert property (disable iff (1'b0) sys_rst_i |-> rdata_o == 8'h00 &&
        !timer_clear_o && channel_select_o == 4'h0 && dac_code_o == 12'h000 && !sample_o)
        else $error("outputs not cleared in reset");
endmodule
bind acs_sequencer acs_sequencer_monitor acs_sequencer_monitor_i (.*);

// ### testbench/tb_acs_sequencer.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ns
module tb_acs_sequencer;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b0;
    logic rc_clk_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic cmp_i = 1'b1;
    logic [7:0] port_pins_i = 8'ha5;
    logic [3:0] trg = 4'h0;
    logic [7:0] rdata_o;
    logic timer_clear_o;
    logic sample_o;
    logic [3:0] channel_select_o;
    logic [11:0] dac_code_o;
    logic [7:0] v;
    logic tc;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int t0;
    acs_sequencer acs_sequencer_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rc_clk_i(rc_clk_i), .cmp_i(cmp_i), .port_pins_i(port_pins_i),
        .trig_compare_i(trg[0]), .trig_charge_i(trg[1]), .trig_timer_i(trg[2]),
        .trig_calendar_i(trg[3]), .timer_clear_o(timer_clear_o), .sample_o(sample_o),
        .channel_select_o(channel_select_o), .dac_code_o(dac_code_o));
    // ==========================================
    // Clocks, watchdog
    initial forever #4 ref_clk_i = ~ref_clk_i;
    // Free-running RC source, 7 system clocks a period, edges kept off the clock edges
    initial #2 forever #28 rc_clk_i = ~rc_clk_i;
    always @(posedge ref_clk_i) cyc <= cyc + 1;
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        num_errors++;
        report_and_stop();
    end
    // ==========================================
    // Tasks
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_len(input int lo, input int hi, input int g);
        n_compared++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("ERROR conversion length expected %0d..%0d seen %0d", lo, hi, g);
        end
    endtask
    task automatic wait_idle();
        v = 8'h02;
        for (int i = 0; i < 700 && v[1] !== 1'b0; i++) rd(acs_pkg::OFS_CTRL0);
    endtask
    task automatic pulse(input int s);
        @(posedge ref_clk_i);
        trg[s] <= 1'b1;
        @(posedge ref_clk_i);
        trg <= 4'h0;
        #1;
        tc = timer_clear_o;
    endtask
    // Length bound allows for the free-running divider phase and polling
    task automatic conv(input logic [7:0] c1, input int d, input int n, input logic [11:0] r);
        wr(acs_pkg::OFS_CTRL1, c1);
        // Post wait of the last run must end first, its length follows the new divider
        #1;
        while (sample_o !== 1'b1) begin
            @(posedge ref_clk_i);
            #1;
        end
        wr(acs_pkg::OFS_CTRL0, 8'h17);
        t0 = cyc;
        wait_idle();
        chk_len((n - 1) * d, (n + 1) * d + 16, cyc - t0);
        chk("trial code", c1[7] ? 12'hfff : 12'h3ff, dac_code_o);
        rd(acs_pkg::OFS_RES_HI);
        chk("result high", {4'h0, r[11:8]}, v);
        rd(acs_pkg::OFS_RES_LO);
        chk("result low", r[7:0], v);
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd(acs_pkg::OFS_CTRL0);
        chk("ctrl0 reset", 8'h00, v);
        rd(acs_pkg::OFS_CTRL1);
        chk("ctrl1 reset", 8'h00, v);
        rd(acs_pkg::OFS_TRIG_SEL);
        chk("trigger select reset", 8'h00, v);
        rd(12'h000);
        chk("unmapped read", 8'h00, v);
        rd(acs_pkg::OFS_PORT_IN);
        chk("port all digital", 8'ha5, v);
        wr(acs_pkg::OFS_ANA_CFG, 8'h0f);
        rd(acs_pkg::OFS_PORT_IN);
        chk("port analog pins", 8'h05, v);
        wr(acs_pkg::OFS_CTRL0, 8'h03);
        rd(acs_pkg::OFS_CTRL0);
        chk("go with enable", 8'h01, v);
        $display("test registers done");
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 8; c++) begin
                conv({m[0], 4'h0, c[2:0]}, (c[1:0] == 2'h3) ? 7 : (2 << (2 * c[1:0] + c[2])),
                    m ? 13 : 11, m ? 12'hfff : 12'h3ff);
            end
        end
        rd(acs_pkg::OFS_STATUS);
        chk("done flag", 1'b1, v[0]);
        conv(8'h90, 2, 17, 12'hfff);
        $display("test conversions done");
        wr(acs_pkg::OFS_RES_HI, 8'h03);
        wr(acs_pkg::OFS_RES_LO, 8'h21);
        wr(acs_pkg::OFS_STATUS, 8'h00);
        wr(acs_pkg::OFS_CTRL0, 8'h17);
        repeat (10) @(posedge ref_clk_i);
        wr(acs_pkg::OFS_CTRL0, 8'h15);
        repeat (40) @(posedge ref_clk_i);
        #1;
        chk("sampling resumes", 1'b1, sample_o);
        rd(acs_pkg::OFS_RES_HI);
        chk("abort result high", 8'h03, v);
        rd(acs_pkg::OFS_RES_LO);
        chk("abort result low", 8'h21, v);
        rd(acs_pkg::OFS_STATUS);
        chk("abort done flag", 1'b0, v[0]);
        $display("test abort done");
        wr(acs_pkg::OFS_CTRL0, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(acs_pkg::OFS_TRIG_SEL, s[7:0]);
            pulse(s);
            chk("timer clear off", s == 0, tc);
            rd(acs_pkg::OFS_CTRL0);
            chk("trigger while off", 8'h00, v);
        end
        wr(acs_pkg::OFS_CTRL0, 8'h15);
        for (int s = 0; s < 4; s++) begin
            wr(acs_pkg::OFS_TRIG_SEL, s[7:0]);
            rd(acs_pkg::OFS_TRIG_SEL);
            chk("trigger select", s[7:0], v);
            pulse((s + 1) % 4);
            rd(acs_pkg::OFS_CTRL0);
            chk("other trigger", 8'h15, v);
            pulse(s);
            chk("timer clear on", s == 0, tc);
            rd(acs_pkg::OFS_CTRL0);
            chk("trigger sets go", 8'h17, v);
            wait_idle();
        end
        $display("test triggers done");
        conv(8'hc0, 2, 13, 12'hfff);
        conv(8'h80, 2, 13, 12'h000);
        $display("test calibration done");
        report_and_stop();
    end
endmodule
